// File: rtl/mro_device.sv
// Device end: second mode register, loop control, termination and latency.
// Assumes the controller loads the register only when idle and spaced.
// What this block and its controller do
// [R1] Register holds until reload, reset or power-off
// [R2] Controller loads only idle, then waits spacing
// [R3] Controller writes zero to reserved bits
// [R4] Write leveling limits termination unless outputs off
// [R5] Bit 0 enables or disables the loop
// [R6] Controller resets loop after enabling it
// [R7] Enabled loop off in self refresh, reset after
// [R8] Disabled loop stays off after self refresh
// [R9] Loop off: no termination, latencies six
// [R10] Bits 5 and 1 select drive impedance
// [R11] Bit 12 tri-states data and strobe outputs
// [R12] Strobe termination on x8 replaces data mask
// [R13] Strobe termination off: mask active, x8 only
// [R14] Bits 9, 6, 2 select nominal termination
// [R15] Controller keeps termination off during reads
// [R16] Dynamic write termination replaces nominal during writes
// [R17] Termination control level switches termination
// [R18] Bit 7 enters write leveling
// [R19] Bits 4, 3 select additive latency
// [R20] Controller may issue column early using additive
// [R21] Commands held additive latency; read latency sum
// [R22] Write latency is additive plus write latency
// [R23] Controller waits 512 cycles before reads
// [R24] Mode command routed by bank, fields together
module mro_device
	import mro_pkg::*;
#(
	parameter bit WIDE_X8 = 1'b1
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	mro_if.device            link,
	input  wire logic [4:0]  readColLatency,
	input  wire logic [4:0]  writeColLatency,
	input  wire logic [2:0]  writeTermCode,
	output logic [17:0]      modeValue,
	output logic             loopEnabled,
	output logic             loopReset,
	output logic             loopLocked,
	output logic [1:0]       driveCode,
	output logic [2:0]       termCode,
	output logic             termFromWrite,
	output logic             writeLeveling,
	output logic             outputsOff,
	output logic [4:0]       addLatency,
	output logic [4:0]       totalReadLatency,
	output logic [4:0]       totalWriteLatency,
	output logic             internalRead,
	output logic             internalWrite,
	output logic             selfRefresh
);

	// ==========================================================
	// Helpers
	function automatic logic tapAt(input logic [MAX_LAT-1:0] pipe, input logic now, input logic [4:0] n);
		tapAt = (n == 5'h00) ? now : pipe[n - 5'h01];
	endfunction : tapAt

	function automatic logic [4:0] addOf(input logic [1:0] code, input logic [4:0] cl);
		unique case (code)
			2'b01:   addOf = cl - 5'h01;
			2'b10:   addOf = cl - 5'h02;
			default: addOf = 5'h00;
		endcase
	endfunction : addOf

	// Write-usable nominal values are the three strongest codes
	function automatic logic writeUsable(input logic [2:0] code);
		writeUsable = (code == 3'b001) || (code == 3'b010) || (code == 3'b011);
	endfunction : writeUsable

	// ==========================================================
	// Decode
	logic modeCmd, readCmd, writeCmd, sreCmd, srxCmd;
	logic [2:0] nomCode;
	logic       strobeTerm;
	logic [4:0] next_add, next_rl, next_wl;

	assign modeCmd  = link.cmd == CMD_MODE;
	assign readCmd  = link.cmd == CMD_READ;
	assign writeCmd = link.cmd == CMD_WRITE;
	assign sreCmd   = link.cmd == CMD_SRE;
	assign srxCmd   = link.cmd == CMD_SRX;
	assign nomCode  = {modeValue[TERM_B2_BIT], modeValue[TERM_B1_BIT], modeValue[TERM_B0_BIT]}; // [R14]
	assign strobeTerm = WIDE_X8 && modeValue[STROBE_TERM_BIT]; // [R13]
	assign next_add = addOf({modeValue[ADD_HI_BIT], modeValue[ADD_LO_BIT]}, readColLatency); // [R19]
	assign next_rl  = 5'(next_add + readColLatency); // [R21]
	assign next_wl  = 5'(next_add + writeColLatency); // [R22]

	// ==========================================================
	// Mode register
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			modeValue <= MR_RESET; // [R1]
		end else if (modeCmd && link.bank == MR1_INDEX) begin
			modeValue <= link.addr; // [R24]
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			driveCode     <= 2'h0;
			writeLeveling <= 1'b0;
			outputsOff    <= 1'b0;
			addLatency    <= 5'h00;
			totalReadLatency  <= 5'h00;
			totalWriteLatency <= 5'h00;
		end else begin
			driveCode     <= {modeValue[DRIVE_HI_BIT], modeValue[DRIVE_LO_BIT]}; // [R10]
			writeLeveling <= modeValue[WRITE_LEVEL_BIT]; // [R18]
			outputsOff    <= modeValue[OUTPUT_OFF_BIT];
			addLatency    <= next_add;
			totalReadLatency  <= next_rl;
			totalWriteLatency <= next_wl;
		end
	end

	// ==========================================================
	// Loop control and self refresh
	logic [9:0] lockCount;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			selfRefresh <= 1'b0;
		end else if (sreCmd) begin
			selfRefresh <= 1'b1;
		end else if (srxCmd) begin
			selfRefresh <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			loopEnabled <= 1'b0;
			loopReset   <= 1'b0;
		end else begin
			loopReset <= 1'b0;
			if (modeCmd && link.bank == MR1_INDEX && !selfRefresh) begin
				loopEnabled <= !link.addr[LOOP_OFF_BIT]; // [R5]
			end else if (sreCmd) begin
				loopEnabled <= 1'b0; // [R7]
			end else if (srxCmd) begin
				loopEnabled <= !modeValue[LOOP_OFF_BIT]; // [R7] [R8]
				loopReset   <= !modeValue[LOOP_OFF_BIT]; // [R7]
			end else if (modeCmd && link.bank == MR0_INDEX && link.addr[MR0_LOOP_RESET_BIT]) begin
				loopReset <= loopEnabled;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			lockCount  <= 10'h000;
			loopLocked <= 1'b0;
		end else begin
			if (loopReset) begin
				lockCount <= 10'(LOOP_LOCK_CK);
			end else if (lockCount != 10'h000) begin
				lockCount <= lockCount - 10'h001;
			end
			loopLocked <= loopEnabled && !loopReset && lockCount == 10'h000;
		end
	end

	// ==========================================================
	// Posted commands and bursts
	logic [MAX_LAT-1:0] readPipe, writePipe;
	logic [2:0] readBurst, writeBurst;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			readPipe      <= '0;
			writePipe     <= '0;
			internalRead  <= 1'b0;
			internalWrite <= 1'b0;
		end else begin
			readPipe      <= {readPipe[MAX_LAT-2:0], readCmd};
			writePipe     <= {writePipe[MAX_LAT-2:0], writeCmd};
			internalRead  <= tapAt(readPipe, readCmd, next_add); // [R21]
			internalWrite <= tapAt(writePipe, writeCmd, next_add); // [R21]
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			readBurst  <= 3'h0;
			writeBurst <= 3'h0;
		end else begin
			if (tapAt(readPipe, readCmd, next_rl)) begin
				readBurst <= 3'(BURST_CK); // [R21]
			end else if (readBurst != 3'h0) begin
				readBurst <= readBurst - 3'h1;
			end
			if (tapAt(writePipe, writeCmd, next_wl)) begin
				writeBurst <= 3'(BURST_CK); // [R22]
			end else if (writeBurst != 3'h0) begin
				writeBurst <= writeBurst - 3'h1;
			end
		end
	end

	// ==========================================================
	// Output drivers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			link.dqOe  <= 1'b0;
			link.dqsOe <= 1'b0;
		end else begin
			link.dqOe  <= tapAt(readPipe, readCmd, next_rl) && !modeValue[OUTPUT_OFF_BIT]; // [R11]
			link.dqsOe <= (tapAt(readPipe, readCmd, next_rl) || readBurst > 3'h1)
				&& !modeValue[OUTPUT_OFF_BIT]; // [R11]
		end
	end

	// ==========================================================
	// Termination
	logic nomAllowed, writeSubst;

	assign nomAllowed = nomCode != 3'b000 && (!modeValue[WRITE_LEVEL_BIT] || modeValue[OUTPUT_OFF_BIT]
		|| writeUsable(nomCode)); // [R4]
	// Dynamic write value is not used during write leveling
	assign writeSubst = writeBurst != 3'h0 && writeTermCode != 3'b000 && !modeValue[WRITE_LEVEL_BIT];

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			link.termOn       <= 1'b0;
			link.strobeTermOn <= 1'b0;
			link.maskActive   <= 1'b1;
			termCode          <= 3'b000;
			termFromWrite     <= 1'b0;
		end else begin
			link.termOn       <= link.die_termination_control && !selfRefresh && (nomAllowed || writeSubst); // [R17]
			link.strobeTermOn <= link.die_termination_control && !selfRefresh && (nomAllowed || writeSubst) && strobeTerm; // [R12]
			link.maskActive   <= !strobeTerm; // [R12] [R13]
			termCode          <= writeSubst ? writeTermCode : (nomAllowed ? nomCode : 3'b000); // [R16]
			termFromWrite     <= writeSubst; // [R16]
		end
	end

endmodule : mro_device

// File: common/mro_pkg.sv
// Shared constants for the second mode register block and its controller.
// Assumes both ends run on the one command clock at the rate below.
package mro_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLOCK_MHZ          = 25;
	localparam int LOOP_LOCK_CK       = 512;
	localparam int MODE_CMD_SPACING_CK = 4;
	localparam int MODE_UPDATE_CK     = 12;
	localparam int ACT_TO_COL_NS      = 15;
	localparam int ACT_TO_COL_CK      = (ACT_TO_COL_NS * CLOCK_MHZ + 999) / 1000;
	localparam int BURST_CK           = 4;
	localparam int MAX_LAT            = 32;
	localparam int LOOP_OFF_LATENCY   = 6;

	// ==========================================================
	// Register selection and fields
	localparam int MR_WIDTH           = 18;
	localparam logic [2:0] MR0_INDEX = 3'h0;
	localparam logic [2:0] MR1_INDEX = 3'h1;
	localparam int MR0_LOOP_RESET_BIT = 8;
	localparam int LOOP_OFF_BIT       = 0;
	localparam int DRIVE_LO_BIT       = 1;
	localparam int DRIVE_HI_BIT       = 5;
	localparam int TERM_B0_BIT        = 2;
	localparam int TERM_B1_BIT        = 6;
	localparam int TERM_B2_BIT        = 9;
	localparam int ADD_LO_BIT         = 3;
	localparam int ADD_HI_BIT         = 4;
	localparam int WRITE_LEVEL_BIT    = 7;
	localparam int STROBE_TERM_BIT    = 11;
	localparam int OUTPUT_OFF_BIT     = 12;
	localparam logic [17:0] RESERVED_MASK = 18'h26500;
	localparam logic [17:0] MR_RESET      = 18'h00000;

	// ==========================================================
	// Commands
	typedef enum logic [2:0] {
		CMD_NOP   = 3'b000,
		CMD_MODE  = 3'b001,
		CMD_ACT   = 3'b010,
		CMD_READ  = 3'b011,
		CMD_WRITE = 3'b100,
		CMD_PRE   = 3'b101,
		CMD_SRE   = 3'b110,
		CMD_SRX   = 3'b111
	} mro_cmd_e;

endpackage : mro_pkg

// File: common/mro_if.sv
// Command and pin link between the memory controller and the device.
// Assumes both ends share one clock; output enables are high while driving.
interface mro_if;
	import mro_pkg::*;
	mro_cmd_e    cmd;
	logic [2:0]  bank;
	logic [17:0] addr;
	logic        cke;
	logic        die_termination_control;
	logic        dqOe;
	logic        dqsOe;
	logic        termOn;
	logic        strobeTermOn;
	logic        maskActive;

	modport device (input cmd, bank, addr, cke, die_termination_control, output dqOe, dqsOe, termOn, strobeTermOn, maskActive);
	modport ctrl   (output cmd, bank, addr, cke, die_termination_control, input dqOe, dqsOe, termOn, strobeTermOn, maskActive);
endinterface : mro_if

// File: rtl/mro_ctrl.sv
// Controller end: issues mode loads and accesses under the register's rules.
// Assumes one request at a time from the user side; refused ones pulse.
module mro_ctrl
	import mro_pkg::*;
#(
	parameter bit WIDE_X8 = 1'b1
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	mro_if.ctrl              link,
	input  wire logic        loadReq,
	input  wire logic [17:0] loadValue,
	input  wire logic [17:0] baseModeZero,
	input  wire logic [4:0]  readColLatency,
	input  wire logic [4:0]  writeColLatency,
	input  wire logic        actReq,
	input  wire logic        readReq,
	input  wire logic        writeReq,
	input  wire logic        preReq,
	input  wire logic        srEnterReq,
	input  wire logic        srExitReq,
	input  wire logic        odtReq,
	output logic             ready,
	output logic             refused
);

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SPACE = 2'b01,
		ST_RESET = 2'b10
	} mro_ctrl_state_e;

	mro_ctrl_state_e state;
	logic [3:0]  waitCount;
	logic [9:0]  lockCount;
	logic [4:0]  actAge, addLat, readHold;
	logic        bankOpen, inSelfRefresh, loopOn, resetPending;
	logic        loadOk, colOk, readOk, busy;

	always_comb begin
		unique case ({loadValue[ADD_HI_BIT], loadValue[ADD_LO_BIT]})
			2'b01:   addLat = readColLatency - 5'h01;
			2'b10:   addLat = readColLatency - 5'h02;
			default: addLat = 5'h00;
		endcase
	end

	assign busy   = state != ST_IDLE || inSelfRefresh;
	assign loadOk = !bankOpen && readHold == 5'h00 && (!loadValue[LOOP_OFF_BIT]
		|| (readColLatency == 5'(LOOP_OFF_LATENCY) && writeColLatency == 5'(LOOP_OFF_LATENCY))); // [R2] [R9]
	assign colOk  = bankOpen && 6'(actAge) + 6'(addLat) >= 6'(ACT_TO_COL_CK); // [R20]
	assign readOk = colOk && lockCount == 10'h000; // [R23]

	// ==========================================================
	// Command sequencing
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state        <= ST_IDLE;
			waitCount    <= 4'h0;
			resetPending <= 1'b0;
			link.cmd     <= CMD_NOP;
			link.bank    <= 3'h0;
			link.addr    <= 18'h00000;
			refused      <= 1'b0;
		end else begin
			link.cmd <= CMD_NOP;
			refused  <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					if (srExitReq && inSelfRefresh) begin
						link.cmd <= CMD_SRX;
					end else if (inSelfRefresh && (loadReq || actReq || readReq || writeReq || preReq)) begin
						refused <= 1'b1;
					end else if (loadReq) begin
						if (loadOk) begin
							link.cmd  <= CMD_MODE;
							link.bank <= MR1_INDEX;
							link.addr <= loadValue & ~RESERVED_MASK
								& ~(WIDE_X8 ? 18'h00000 : 18'(1) << STROBE_TERM_BIT); // [R3] [R13]
							resetPending <= !loadValue[LOOP_OFF_BIT]; // [R6]
							waitCount <= 4'(MODE_UPDATE_CK); // [R2]
							state     <= ST_SPACE;
						end else begin
							refused <= 1'b1;
						end
					end else if (actReq) begin
						link.cmd <= CMD_ACT;
					end else if (readReq) begin
						if (readOk) begin
							link.cmd <= CMD_READ;
						end else begin
							refused <= 1'b1;
						end
					end else if (writeReq) begin
						if (colOk) begin
							link.cmd <= CMD_WRITE;
						end else begin
							refused <= 1'b1;
						end
					end else if (preReq) begin
						link.cmd <= CMD_PRE;
					end else if (srEnterReq) begin
						if (!bankOpen && lockCount == 10'h000) begin
							link.cmd <= CMD_SRE;
						end else begin
							refused <= 1'b1;
						end
					end
				end
				ST_SPACE: begin
					if (waitCount > 4'h1) begin
						waitCount <= waitCount - 4'h1;
					end else begin
						state <= resetPending ? ST_RESET : ST_IDLE;
					end
				end
				ST_RESET: begin
					link.cmd     <= CMD_MODE;
					link.bank    <= MR0_INDEX;
					link.addr    <= baseModeZero | (18'(1) << MR0_LOOP_RESET_BIT); // [R6]
					resetPending <= 1'b0;
					waitCount    <= 4'(MODE_UPDATE_CK);
					state        <= ST_SPACE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Tracking
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			bankOpen      <= 1'b0;
			actAge        <= 5'h00;
			inSelfRefresh <= 1'b0;
			loopOn        <= 1'b0;
			lockCount     <= 10'h000;
			readHold      <= 5'h00;
		end else begin
			if (link.cmd == CMD_ACT) begin
				bankOpen <= 1'b1;
				actAge   <= 5'h01;
			end else if (link.cmd == CMD_PRE) begin
				bankOpen <= 1'b0;
			end else if (actAge != 5'h1f) begin
				actAge <= actAge + 5'h01;
			end
			if (link.cmd == CMD_SRE) begin
				inSelfRefresh <= 1'b1;
			end else if (link.cmd == CMD_SRX) begin
				inSelfRefresh <= 1'b0;
			end
			if (link.cmd == CMD_MODE && link.bank == MR1_INDEX) begin
				loopOn <= !link.addr[LOOP_OFF_BIT]; // [R5]
			end
			if ((link.cmd == CMD_MODE && link.bank == MR0_INDEX) || (link.cmd == CMD_SRX && loopOn)) begin
				lockCount <= 10'(LOOP_LOCK_CK); // [R23]
			end else if (lockCount != 10'h000) begin
				lockCount <= lockCount - 10'h001;
			end
			if (link.cmd == CMD_READ) begin
				readHold <= 5'(addLat + readColLatency + 5'(BURST_CK)); // [R15]
			end else if (readHold != 5'h00) begin
				readHold <= readHold - 5'h01;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			link.cke <= 1'b0;
			link.die_termination_control <= 1'b0;
			ready    <= 1'b0;
		end else begin
			link.cke <= 1'b1; // [R23]
			link.die_termination_control <= odtReq && loopOn && !inSelfRefresh && readHold == 5'h00
				&& link.cmd != CMD_READ; // [R9] [R15] [R17]
			ready    <= !busy;
		end
	end

endmodule : mro_ctrl

// File: sim/mro_link_chk.sv
// Concurrent checks on the command link between controller and device.
// Assumes one clock domain; tb instantiates it beside the link it watches.
module mro_link_chk
	import mro_pkg::*;
#(
	parameter int READ_CL = 6
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire mro_cmd_e    cmd,
	input  wire logic [2:0]  bank,
	input  wire logic [17:0] addr,
	input  wire logic        cke,
	input  wire logic        die_termination_control,
	input  wire logic        dqOe,
	input  wire logic        dqsOe,
	input  wire logic        termOn,
	input  wire logic        strobeTermOn,
	input  wire logic        maskActive
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Shadow of the register and ages of link events
	logic [17:0] shadow;
	logic [1:0]  sinceLoad;
	logic [9:0]  lockAge;
	logic [5:0]  readAge;
	logic        inRefresh;
	int          rl;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			shadow    <= MR_RESET;
			sinceLoad <= 2'h3;
		end else if (cmd == CMD_MODE && bank == MR1_INDEX) begin
			shadow    <= addr;
			sinceLoad <= 2'h0;
		end else if (sinceLoad != 2'h3) begin
			sinceLoad <= sinceLoad + 2'h1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) lockAge <= 10'h0;
		else if (cmd == CMD_MODE && bank == MR0_INDEX && addr[MR0_LOOP_RESET_BIT]) lockAge <= 10'h1;
		else if (lockAge != 10'h3ff) lockAge <= lockAge + 10'h1;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) readAge <= 6'h3f;
		else if (cmd == CMD_READ) readAge <= 6'h1;
		else if (readAge != 6'h3f) readAge <= readAge + 6'h1;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) inRefresh <= 1'b0;
		else if (cmd == CMD_SRE) inRefresh <= 1'b1;
		else if (cmd == CMD_SRX) inRefresh <= 1'b0;
	end

	always_comb begin
		case (shadow[ADD_HI_BIT:ADD_LO_BIT])
			2'h1: rl = 2 * READ_CL - 1;
			2'h2: rl = 2 * READ_CL - 2;
			default: rl = READ_CL;
		endcase
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence loadThisReg;
		cmd == CMD_MODE && bank == MR1_INDEX;
	endsequence
	sequence loopResetLoad;
		cmd == CMD_MODE && bank == MR0_INDEX && addr[MR0_LOOP_RESET_BIT];
	endsequence
	sequence readBurst;
		dqsOe [*4] ##1 !dqsOe;
	endsequence

	chk_reserved_zero: assert property (loadThisReg |-> (addr & RESERVED_MASK) == 18'h0)
		else $error("reserved bits set in a register load");
	chk_loop_reset_follows: assert property (loadThisReg ##0 !addr[LOOP_OFF_BIT] |-> ##[12:14] loopResetLoad)
		else $error("loop enable load not followed by loop reset");
	chk_mode_spacing: assert property (cmd == CMD_MODE |=> (cmd == CMD_NOP) [*8])
		else $error("command issued too soon after a mode load");
	chk_read_after_lock: assert property (cmd == CMD_READ |-> cke && lockAge >= LOOP_LOCK_CK)
		else $error("read issued before loop lock time");
	chk_outputs_quiet: assert property (sinceLoad == 2'h3 && shadow[OUTPUT_OFF_BIT] |-> !dqOe && !dqsOe)
		else $error("outputs driven while disabled");
	chk_mask_ball: assert property (sinceLoad == 2'h3 |-> maskActive == !shadow[STROBE_TERM_BIT])
		else $error("mask ball function does not follow strobe termination bit");
	chk_strobe_term: assert property (strobeTermOn |-> termOn && shadow[STROBE_TERM_BIT])
		else $error("strobe pair terminated without data strobe termination");
	chk_term_by_odt: assert property (termOn |-> die_termination_control || $past(die_termination_control))
		else $error("termination applied without termination control");
	chk_refresh_term: assert property (inRefresh && $past(inRefresh) |-> !termOn)
		else $error("termination applied in self refresh");
	chk_read_burst: assert property ($rose(dqsOe) |-> readBurst)
		else $error("read strobe burst length wrong");
	chk_read_latency: assert property ($rose(dqsOe) |-> readAge >= rl && readAge <= rl + 2)
		else $error("read data not at total read latency");
endmodule : mro_link_chk

// File: sim/tb.sv
// Testbench: controller and device joined by the link, driven from the user side.
// Assumes inputs change on the falling edge and the checker sits beside the link.
module tb
	import mro_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin badCount++; \
	$display("Error at %0t: got %h expected %h", $time, got, exp); end end

	localparam int LAT = 6;
	logic        clock, nrst, odtReq, ready, refused, r;
	logic [6:0]  reqs;
	logic [17:0] loadValue, modeValue, v;
	logic [4:0]  colLat, al, addLatency, totalReadLatency, totalWriteLatency;
	logic [1:0]  driveCode;
	logic        loopEnabled, loopReset, writeLeveling, outputsOff, internalRead, internalWrite, selfRefresh;
	logic        loopLocked, termFromWrite;
	logic [2:0]  termCode, wrTerm;
	int          badCount, comparisons, loopPulses, edges;
	logic [17:0] loadTable [8] = '{18'h00002, 18'h00024, 18'h00048, 18'h00214, 18'h00208, 18'h010c4, 18'h26522,
		18'h00818};

	mro_if link();
	mro_device i_mro_device (.clock(clock), .nrst(nrst), .link(link), .readColLatency(colLat),
		.writeColLatency(colLat), .writeTermCode(wrTerm), .modeValue(modeValue), .loopEnabled(loopEnabled),
		.loopReset(loopReset), .loopLocked(loopLocked), .driveCode(driveCode), .termCode(termCode),
		.termFromWrite(termFromWrite),
		.writeLeveling(writeLeveling), .outputsOff(outputsOff), .addLatency(addLatency),
		.totalReadLatency(totalReadLatency), .totalWriteLatency(totalWriteLatency),
		.internalRead(internalRead), .internalWrite(internalWrite), .selfRefresh(selfRefresh));
	mro_ctrl i_mro_ctrl (.clock(clock), .nrst(nrst), .link(link), .loadReq(reqs[6]), .loadValue(loadValue),
		.baseModeZero(18'h0), .readColLatency(colLat), .writeColLatency(colLat), .actReq(reqs[5]),
		.readReq(reqs[4]), .writeReq(reqs[3]), .preReq(reqs[2]), .srEnterReq(reqs[1]), .srExitReq(reqs[0]),
		.odtReq(odtReq), .ready(ready), .refused(refused));
	mro_link_chk #(.READ_CL(LAT)) i_mro_link_chk (.clock(clock), .nrst(nrst), .cmd(link.cmd), .bank(link.bank),
		.addr(link.addr), .cke(link.cke), .die_termination_control(link.die_termination_control), .dqOe(link.dqOe), .dqsOe(link.dqsOe),
		.termOn(link.termOn), .strobeTermOn(link.strobeTermOn), .maskActive(link.maskActive));

	// ==========================================================
	// Clock, pulse counting and watchdog
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	always @(negedge clock) if (loopReset === 1'b1) loopPulses++;

	initial begin
		repeat (30000) @(posedge clock);
		badCount++;
		printVerdict();
	end

	// ==========================================================
	// Access tasks
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask : tick

	task automatic waitReady;
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 1000) begin
			tick(1);
			n++;
		end
		if (n >= 1000) `CHECK(ready, 1'b1)
	endtask : waitReady

	task automatic request(input logic [6:0] which, output logic sawRefusal);
		reqs = which;
		sawRefusal = 1'b0;
		tick(1);
		reqs = 7'h0;
		repeat (3) begin
			sawRefusal = sawRefusal | (refused === 1'b1);
			tick(1);
		end
	endtask : request

	task automatic loadReg(input logic [17:0] mv);
		logic rf;
		loadValue = mv;
		request(7'h40, rf);
		waitReady();
	endtask : loadReg

	task automatic measure(input logic [6:0] which, output int n);
		reqs = which;
		tick(1);
		reqs = 7'h0;
		n = 1;
		while (internalRead !== 1'b1 && internalWrite !== 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
	endtask : measure

	task automatic accessRound(input logic [17:0] mv, input int alExp);
		logic rf;
		loadReg(mv);
		tick(LOOP_LOCK_CK + 8);
		request(7'h20, rf);
		waitReady();
		measure(7'h10, edges);
		`CHECK(edges, alExp + 2)
		tick(20);
		waitReady();
		measure(7'h08, edges);
		`CHECK(edges, alExp + 2)
		tick(7);
		`CHECK(termFromWrite, 1'b1)
		`CHECK(termCode, 3'h2)
		tick(13);
		waitReady();
		request(7'h40, rf);
		`CHECK(rf, 1'b1)
		request(7'h04, rf);
		waitReady();
	endtask : accessRound

	task automatic printVerdict;
		$display("Comparisons %0d, mismatches %0d", comparisons, badCount);
		if (badCount == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : printVerdict

	// ==========================================================
	// Test sequence
	initial begin
		nrst = 1'b0;
		reqs = 7'h0;
		odtReq = 1'b0;
		loadValue = 18'h0;
		wrTerm = 3'h2;
		colLat = 5'(LAT);
		tick(20);
		nrst = 1'b1;
		tick(1);
		`CHECK(modeValue, MR_RESET)
		`CHECK(link.maskActive, 1'b1)
		foreach (loadTable[i]) begin
			v = loadTable[i];
			loadReg(v);
			al = (v[4:3] == 2'h1) ? colLat - 5'h1 : (v[4:3] == 2'h2) ? colLat - 5'h2 : 5'h0;
			`CHECK(modeValue, v & ~RESERVED_MASK)
			`CHECK(driveCode, {v[5], v[1]})
			`CHECK(writeLeveling, v[7])
			`CHECK(outputsOff, v[12])
			`CHECK(link.maskActive, ~v[11])
			`CHECK(addLatency, al)
			`CHECK(totalReadLatency, al + colLat)
			`CHECK(totalWriteLatency, al + colLat)
			`CHECK(loopEnabled, 1'b1)
		end
		`CHECK(loopPulses, 8)
		accessRound(18'h00000, 0);
		accessRound(18'h00010, LAT - 2);
		accessRound(18'h01008, LAT - 1);
		// Strobe termination and self refresh with the loop on
		loadReg(18'h00804);
		tick(LOOP_LOCK_CK + 8);
		`CHECK(loopLocked, 1'b1)
		odtReq = 1'b1;
		tick(3);
		`CHECK(link.termOn, 1'b1)
		`CHECK(termCode, 3'h1)
		`CHECK(link.strobeTermOn, 1'b1)
		request(7'h02, r);
		`CHECK(selfRefresh, 1'b1)
		`CHECK(loopEnabled, 1'b0)
		`CHECK(link.termOn, 1'b0)
		request(7'h01, r);
		`CHECK(loopEnabled, 1'b1)
		`CHECK(loopPulses, 13)
		`CHECK(loopLocked, 1'b0)
		odtReq = 1'b0;
		tick(2);
		waitReady();
		`CHECK(link.termOn, 1'b0)
		// Loop off: refused unless both latencies are six
		colLat = 5'h7;
		loadValue = 18'h00001;
		request(7'h40, r);
		`CHECK(r, 1'b1)
		colLat = 5'(LAT);
		loadReg(18'h00001);
		`CHECK(loopEnabled, 1'b0)
		tick(LOOP_LOCK_CK);
		request(7'h02, r);
		`CHECK(selfRefresh, 1'b1)
		request(7'h01, r);
		waitReady();
		`CHECK(loopEnabled, 1'b0)
		`CHECK(loopPulses, 13)
		// Reset in mid-run clears the register
		nrst = 1'b0;
		tick(2);
		`CHECK(modeValue, MR_RESET)
		nrst = 1'b1;
		tick(2);
		printVerdict();
	end
endmodule : tb
